//--- core/xpe_cfg.svh
// constants for the extension peripheral enable register and its address windows
`ifndef XPE_CFG_SVH
`define XPE_CFG_SVH

`define XPE_ADDR_W        16
`define XPE_DATA_W        16
`define XPE_ACC_W         24
`define XPE_EN_W          5
`define XPE_ENSEL_OFFSET  16'hf024
`define XPE_ENSEL_RESET   5'h05
`define XPE_ZERO_DATA     16'h0000
`define XPE_ZERO_ACC      24'h00_0000

`define XPE_CAN1_LO       24'h00_ef00
`define XPE_CAN1_HI       24'h00_efff
`define XPE_CAN2_LO       24'h00_ee00
`define XPE_CAN2_HI       24'h00_eeff
`define XPE_PWM_LO        24'h00_ec00
`define XPE_PWM_HI        24'h00_ecff
`define XPE_SHARED_LO     24'h00_ec00
`define XPE_SHARED_HI     24'h00_efff

`define XPE_EXTENSION_RAM_LO       24'h00_c000
`define XPE_EXTENSION_RAM_HI       24'h00_ffff
`define XPE_AUX_LO        24'h00_e000
`define XPE_AUX_HI        24'h00_e7ff

`endif

//--- core/xpe_pkg.sv
// types shared by the extension peripheral enable block
package xpe_pkg;

	typedef struct packed
	{
		logic pwm;
		logic auxGroup;
		logic extRam;
		logic secondCan;
		logic firstCan;
	} xpe_enables_t;

	typedef enum logic [2:0]
	{
		TGT_OTHER   = 3'b000,
		TGT_CAN1    = 3'b001,
		TGT_CAN2    = 3'b010,
		TGT_EXTENSION_RAM    = 3'b011,
		TGT_AUX     = 3'b100,
		TGT_PWM     = 3'b101,
		TGT_EXT     = 3'b110,
		TGT_BLOCKED = 3'b111
	} xpe_target_t;

	typedef enum logic
	{
		LOCK_OPEN   = 1'b0,
		LOCK_FROZEN = 1'b1
	} xpe_lock_t;

	typedef struct packed
	{
		logic                 done;
		xpe_target_t          target;
		logic                 external;
		logic [23:0]          addr;
	} xpe_route_t;

endpackage : xpe_pkg

//--- core/xpe_lock_reg.sv
// enable register storage with the freeze after global enabling
`include "xpe_cfg.svh"

module xpe_lock_reg
(
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  wrStrobe,
	input  wire logic [`XPE_EN_W-1:0]  wrData,
	input  wire logic                  globalXperEnable,
	output xpe_pkg::xpe_enables_t      enables,
	output logic                       locked,
	output logic                       wrIgnored
);

	xpe_pkg::xpe_lock_t lock_reg;
	logic               frozenNow;

	// the write that meets the first set of the global enable is already refused
	assign frozenNow = (lock_reg == xpe_pkg::LOCK_FROZEN) || globalXperEnable;

	// ************************************************
	// lock state
	// ************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			lock_reg <= xpe_pkg::LOCK_OPEN;
		else
		begin
			case (lock_reg)
				xpe_pkg::LOCK_OPEN:
					if (globalXperEnable)
						lock_reg <= xpe_pkg::LOCK_FROZEN; // R10
				xpe_pkg::LOCK_FROZEN:
					lock_reg <= xpe_pkg::LOCK_FROZEN;
				default:
					lock_reg <= xpe_pkg::LOCK_FROZEN;
			endcase
		end
	end

	// ************************************************
	// enable bits
	// ************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			enables <= xpe_pkg::xpe_enables_t'(`XPE_ENSEL_RESET); // R9
		else if (wrStrobe && !frozenNow)
			enables <= xpe_pkg::xpe_enables_t'(wrData);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			locked <= 1'b0;
		else
			locked <= frozenNow;
	end

	// refused write leaves no error, only this status pulse
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wrIgnored <= 1'b0;
		else
			wrIgnored <= wrStrobe && frozenNow; // R11
	end

endmodule : xpe_lock_reg

//--- core/xpe_enable_select.sv
// extension peripheral enable register and access routing
// How it works
// R1: with the first CAN enable clear its unit is blocked and port 4 bits 5 and 6 are free.
// R2: the first CAN window goes external only when both CAN and the PWM enables are clear.
// R3: with the second CAN enable clear its unit is blocked and port 4 bits 4 and 7 are free.
// R4: the second CAN window goes external only when both CAN and the PWM enables are clear.
// R5: with the extension RAM enable clear its accesses become external accesses.
// R6: bit 3 enables both aux ports, the aux timer and the ADC mux together, else external.
// R7: with the PWM enable clear its window goes external only if both CAN enables are clear.
// R8: with both CAN and PWM off the whole shared window goes to the external bus interface.
// R9: after reset the register reads 05h, first CAN and extension RAM on, the rest off.
// R10: once the global extension enable is set the register can no longer change.
// R11: late writes are dropped silently, reads always return the bits, upper bits zero.
//
// The strobed register port was decided locally.
`include "xpe_cfg.svh"

module xpe_enable_select
#(
	parameter logic [`XPE_ACC_W-1:0] EXTENSION_RAM_LO = `XPE_EXTENSION_RAM_LO,
	parameter logic [`XPE_ACC_W-1:0] EXTENSION_RAM_HI = `XPE_EXTENSION_RAM_HI,
	parameter logic [`XPE_ACC_W-1:0] AUX_LO  = `XPE_AUX_LO,
	parameter logic [`XPE_ACC_W-1:0] AUX_HI  = `XPE_AUX_HI
)
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic [`XPE_ADDR_W-1:0] regAddr,
	input  wire logic [`XPE_DATA_W-1:0] regWrData,
	input  wire logic                   regWrStrobe,
	input  wire logic                   regRdStrobe,
	output logic      [`XPE_DATA_W-1:0] regRdData,
	input  wire logic                   globalXperEnable,
	input  wire logic                   accValid,
	input  wire logic [`XPE_ACC_W-1:0]  accAddr,
	output xpe_pkg::xpe_route_t         accRoute,
	output logic                        firstCanSel,
	output logic                        secondCanSel,
	output logic                        extRamSel,
	output logic                        auxGroupSel,
	output logic                        extPwmSel,
	output logic                        accBlocked,
	output xpe_pkg::xpe_enables_t       enables,
	output logic                        port4Bit4Gpio,
	output logic                        port4Bit5Gpio,
	output logic                        port4Bit6Gpio,
	output logic                        port4Bit7Gpio,
	output logic                        xperLocked,
	output logic                        wrIgnored
);

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic inWindow
	(
		input logic [`XPE_ACC_W-1:0] addr,
		input logic [`XPE_ACC_W-1:0] lo,
		input logic [`XPE_ACC_W-1:0] hi
	);
		inWindow = (addr >= lo) && (addr <= hi);
	endfunction : inWindow

	// route for a unit that owns a slice of the shared window
	function automatic xpe_pkg::xpe_target_t sharedRoute
	(
		input logic                  ownEnable,
		input logic                  anyShared,
		input xpe_pkg::xpe_target_t  own
	);
		if (ownEnable)
			sharedRoute = own;
		else if (anyShared)
			sharedRoute = xpe_pkg::TGT_BLOCKED;
		else
			sharedRoute = xpe_pkg::TGT_EXT;
	endfunction : sharedRoute

	// route for a unit with a window of its own
	function automatic xpe_pkg::xpe_target_t ownRoute
	(
		input logic                  ownEnable,
		input xpe_pkg::xpe_target_t  own
	);
		if (ownEnable)
			ownRoute = own;
		else
			ownRoute = xpe_pkg::TGT_EXT;
	endfunction : ownRoute

	// ************************************************
	// register port decode
	// ************************************************
	logic regHit;
	logic regWrite;
	logic regRead;

	assign regHit   = (regAddr == `XPE_ENSEL_OFFSET);
	assign regWrite = regWrStrobe && regHit;
	assign regRead  = regRdStrobe && regHit;

	// ************************************************
	// enable register
	// ************************************************
	xpe_pkg::xpe_enables_t enQ;
	logic                  lockedQ;
	logic                  ignoredQ;

	xpe_lock_reg u_lock_reg
	(
		.clk              (clk),
		.resetn           (resetn),
		.wrStrobe         (regWrite),
		.wrData           (regWrData[`XPE_EN_W-1:0]),
		.globalXperEnable (globalXperEnable),
		.enables          (enQ),
		.locked           (lockedQ),
		.wrIgnored        (ignoredQ)
	);

	assign enables    = enQ;
	assign xperLocked = lockedQ;
	assign wrIgnored  = ignoredQ;

	// ************************************************
	// read data, valid only in the cycle after the strobe
	// ************************************************
	logic [`XPE_DATA_W-1:0] rdData_next;

	always_comb
	begin
		rdData_next = `XPE_ZERO_DATA;
		if (regRead)
			rdData_next = {{(`XPE_DATA_W-`XPE_EN_W){1'b0}}, enQ}; // R11
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			regRdData <= `XPE_ZERO_DATA;
		else
			regRdData <= rdData_next;
	end

	// ************************************************
	// port 4 pin release
	// ************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			port4Bit4Gpio <= 1'b0;
			port4Bit5Gpio <= 1'b0;
			port4Bit6Gpio <= 1'b0;
			port4Bit7Gpio <= 1'b0;
		end
		else
		begin
			port4Bit5Gpio <= !enQ.firstCan; // R1
			port4Bit6Gpio <= !enQ.firstCan; // R1
			port4Bit4Gpio <= !enQ.secondCan; // R3
			port4Bit7Gpio <= !enQ.secondCan; // R3
		end
	end

	// ************************************************
	// access routing
	// ************************************************
	logic                 anyShared;
	xpe_pkg::xpe_target_t target_next;

	// any of these keeps the whole shared window on chip
	assign anyShared = enQ.firstCan || enQ.secondCan || enQ.pwm;

	always_comb
	begin
		target_next = xpe_pkg::TGT_OTHER;
		if (inWindow(accAddr, `XPE_CAN1_LO, `XPE_CAN1_HI))
			target_next = sharedRoute(enQ.firstCan, anyShared, xpe_pkg::TGT_CAN1); // R1 R2
		else if (inWindow(accAddr, `XPE_CAN2_LO, `XPE_CAN2_HI))
			target_next = sharedRoute(enQ.secondCan, anyShared, xpe_pkg::TGT_CAN2); // R3 R4
		else if (inWindow(accAddr, `XPE_PWM_LO, `XPE_PWM_HI))
			target_next = sharedRoute(enQ.pwm, anyShared, xpe_pkg::TGT_PWM); // R7
		else if (inWindow(accAddr, `XPE_SHARED_LO, `XPE_SHARED_HI))
		begin
			// gap between the PWM and second CAN slices
			if (anyShared)
				target_next = xpe_pkg::TGT_BLOCKED;
			else
				target_next = xpe_pkg::TGT_EXT; // R8
		end
		else if (inWindow(accAddr, AUX_LO, AUX_HI))
			target_next = ownRoute(enQ.auxGroup, xpe_pkg::TGT_AUX); // R6
		else if (inWindow(accAddr, EXTENSION_RAM_LO, EXTENSION_RAM_HI))
			target_next = ownRoute(enQ.extRam, xpe_pkg::TGT_EXTENSION_RAM); // R5
	end

	// ************************************************
	// registered route
	// ************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			accRoute.done     <= 1'b0;
			accRoute.target   <= xpe_pkg::TGT_OTHER;
			accRoute.external <= 1'b0;
			accRoute.addr     <= `XPE_ZERO_ACC;
		end
		else
		begin
			accRoute.done <= accValid;
			if (accValid)
			begin
				accRoute.target   <= target_next;
				// bus controller picks its config set by its own address match
				accRoute.external <= (target_next == xpe_pkg::TGT_EXT); // R8
				accRoute.addr     <= accAddr;
			end
			else
			begin
				accRoute.target   <= xpe_pkg::TGT_OTHER;
				accRoute.external <= 1'b0;
			end
		end
	end

	// ************************************************
	// one-cycle unit selects
	// ************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			firstCanSel  <= 1'b0;
			secondCanSel <= 1'b0;
			extPwmSel    <= 1'b0;
		end
		else
		begin
			firstCanSel  <= accValid && (target_next == xpe_pkg::TGT_CAN1); // R1
			secondCanSel <= accValid && (target_next == xpe_pkg::TGT_CAN2); // R3
			extPwmSel    <= accValid && (target_next == xpe_pkg::TGT_PWM); // R7
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			extRamSel   <= 1'b0;
			auxGroupSel <= 1'b0;
		end
		else
		begin
			extRamSel   <= accValid && (target_next == xpe_pkg::TGT_EXTENSION_RAM); // R5
			auxGroupSel <= accValid && (target_next == xpe_pkg::TGT_AUX); // R6
		end
	end

	// disabled unit inside a window still claimed on chip
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			accBlocked <= 1'b0;
		else
			accBlocked <= accValid && (target_next == xpe_pkg::TGT_BLOCKED);
	end

endmodule : xpe_enable_select

//--- dv/xpe_enable_select_properties.sv
// concurrent checks on the ports of the extension peripheral enable block
`include "xpe_cfg.svh"

module xpe_enable_select_properties
(
	input wire logic                   clk,
	input wire logic                   resetn,
	input wire logic [`XPE_ADDR_W-1:0] regAddr,
	input wire logic [`XPE_DATA_W-1:0] regWrData,
	input wire logic                   regWrStrobe,
	input wire logic                   regRdStrobe,
	input wire logic [`XPE_DATA_W-1:0] regRdData,
	input wire logic                   globalXperEnable,
	input wire logic                   accValid,
	input wire logic [`XPE_ACC_W-1:0]  accAddr,
	input wire xpe_pkg::xpe_route_t    accRoute,
	input wire xpe_pkg::xpe_enables_t  enables,
	input wire logic                   port4Bit4Gpio,
	input wire logic                   port4Bit5Gpio,
	input wire logic                   xperLocked,
	input wire logic                   wrIgnored
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	rd_data_a: assert property (regRdStrobe && regAddr == 16'hf024 |=>
		regRdData == {11'h000, $past(enables)}) else $error("read data wrong");
	wr_apply_a: assert property (regWrStrobe && regAddr == 16'hf024 &&
		!xperLocked && !globalXperEnable |=> enables == $past(regWrData[4:0]))
		else $error("write not applied");
	lock_freeze_a: assert property ((xperLocked || globalXperEnable) |=> $stable(enables))
		else $error("enables changed after lock");
	lock_sticky_a: assert property ((xperLocked || globalXperEnable) |=> xperLocked)
		else $error("lock not held");
	wr_ignore_a: assert property (regWrStrobe && regAddr == 16'hf024 &&
		(xperLocked || globalXperEnable) |=> wrIgnored) else $error("refusal not flagged");
	gpio_can1_a: assert property ($past(resetn) |-> port4Bit5Gpio == !$past(enables.firstCan))
		else $error("first can pins wrong");
	gpio_can2_a: assert property ($past(resetn) |-> port4Bit4Gpio == !$past(enables.secondCan))
		else $error("second can pins wrong");
	can1_route_a: assert property (accValid && accAddr[23:8] == 16'h00ef && enables.firstCan
		|=> accRoute.done && accRoute.target == xpe_pkg::TGT_CAN1) else $error("can1 not routed");
	shared_ext_a: assert property (accValid && accAddr[23:10] == 14'h003b &&
		!enables.firstCan && !enables.secondCan && !enables.pwm
		|=> accRoute.external && accRoute.target == xpe_pkg::TGT_EXT) else $error("not external");
endmodule : xpe_enable_select_properties

bind xpe_enable_select xpe_enable_select_properties i_props
(
	.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
	.globalXperEnable(globalXperEnable), .accValid(accValid), .accAddr(accAddr),
	.accRoute(accRoute), .enables(enables), .port4Bit4Gpio(port4Bit4Gpio),
	.port4Bit5Gpio(port4Bit5Gpio), .xperLocked(xperLocked), .wrIgnored(wrIgnored)
);

//--- dv/xpe_cpu_model.sv
// cpu side model issuing one access pulse per request
module xpe_cpu_model
(
	input  wire logic        clk,
	input  wire logic        reqGo,
	input  wire logic [23:0] reqAddr,
	output logic             accValid,
	output logic      [23:0] accAddr
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle address flips so nothing stale looks valid
	always @(posedge clk)
	begin
		accValid <= reqGo;
		accAddr <= reqGo ? reqAddr : ~accAddr;
	end
endmodule : xpe_cpu_model

//--- dv/tb.sv
// self-checking bench for the extension peripheral enable block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk, resetn, regWrStrobe, regRdStrobe, globalXperEnable;
	logic                  reqGo, accValid, xperLocked, wrIgnored;
	logic                  p4b4, p4b5, p4b6, p4b7;
	logic                  c1Sel, c2Sel, xrSel, axSel, pwSel, blSel;
	logic           [15:0] regAddr, regWrData, regRdData, d;
	logic           [23:0] reqAddr, accAddr;
	xpe_pkg::xpe_route_t   accRoute;
	xpe_pkg::xpe_enables_t enables, modelEn;
	int                    miscompares, num_checks;
	localparam logic [23:0] ADDRS [8] = '{24'h00_ef10, 24'h00_ee20, 24'h00_ec30,
		24'h00_ed40, 24'h00_e100, 24'h00_c010, 24'h00_f800, 24'h00_1234};

	xpe_cpu_model i_cpu (.clk(clk), .reqGo(reqGo), .reqAddr(reqAddr), .accValid(accValid),
		.accAddr(accAddr));
	xpe_enable_select i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
		.regRdData(regRdData), .globalXperEnable(globalXperEnable), .accValid(accValid),
		.accAddr(accAddr), .accRoute(accRoute), .firstCanSel(c1Sel), .secondCanSel(c2Sel),
		.extRamSel(xrSel), .auxGroupSel(axSel), .extPwmSel(pwSel), .accBlocked(blSel),
		.enables(enables),
		.port4Bit4Gpio(p4b4), .port4Bit5Gpio(p4b5), .port4Bit6Gpio(p4b6),
		.port4Bit7Gpio(p4b7), .xperLocked(xperLocked), .wrIgnored(wrIgnored));

	function automatic xpe_pkg::xpe_target_t tgt(input logic [23:0] a,
		input xpe_pkg::xpe_enables_t e);
		logic any;
		any = e.firstCan | e.secondCan | e.pwm;
		if (a[23:8] == 16'h00ef) return e.firstCan ? xpe_pkg::TGT_CAN1 :
			any ? xpe_pkg::TGT_BLOCKED : xpe_pkg::TGT_EXT;
		if (a[23:8] == 16'h00ee) return e.secondCan ? xpe_pkg::TGT_CAN2 :
			any ? xpe_pkg::TGT_BLOCKED : xpe_pkg::TGT_EXT;
		if (a[23:8] == 16'h00ec) return e.pwm ? xpe_pkg::TGT_PWM :
			any ? xpe_pkg::TGT_BLOCKED : xpe_pkg::TGT_EXT;
		if (a[23:8] == 16'h00ed) return any ? xpe_pkg::TGT_BLOCKED : xpe_pkg::TGT_EXT;
		if (a >= 24'h00_e000 && a <= 24'h00_e7ff)
			return e.auxGroup ? xpe_pkg::TGT_AUX : xpe_pkg::TGT_EXT;
		if (a[23:14] == 10'h003) return e.extRam ? xpe_pkg::TGT_EXTENSION_RAM : xpe_pkg::TGT_EXT;
		return xpe_pkg::TGT_OTHER;
	endfunction : tgt

	task automatic complete_run;
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		regAddr <= a;
		regWrData <= v;
		regWrStrobe <= 1'b1;
		@(posedge clk);
		regWrStrobe <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge clk);
		regRdStrobe <= 1'b0;
		#1;
		chk(24'(regRdData), 24'(exp));
		@(posedge clk) #1;
		chk(24'(regRdData), 24'h00_0000);
	endtask : rd

	task automatic acc(input logic [23:0] a);
		int n;
		xpe_pkg::xpe_target_t t;
		t = tgt(a, modelEn);
		reqAddr <= a;
		reqGo <= 1'b1;
		@(posedge clk) #1;
		reqGo <= 1'b0;
		for (n = 0; n < 4 && accRoute.done !== 1'b1; n++)
			@(posedge clk) #1;
		if (n == 4)
		begin
			miscompares++;
			complete_run();
		end
		chk(24'(accRoute.target), 24'(t));
		chk(24'(accRoute.external), 24'(t == xpe_pkg::TGT_EXT));
		chk(accRoute.addr, a);
		chk(24'({c1Sel, c2Sel, xrSel, axSel, pwSel, blSel}), 24'({t == xpe_pkg::TGT_CAN1,
			t == xpe_pkg::TGT_CAN2, t == xpe_pkg::TGT_EXTENSION_RAM, t == xpe_pkg::TGT_AUX,
			t == xpe_pkg::TGT_PWM, t == xpe_pkg::TGT_BLOCKED}));
	endtask : acc

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		{resetn, regWrStrobe, regRdStrobe, globalXperEnable, reqGo} = 5'h00;
		regAddr = 16'h0000;
		regWrData = 16'h0000;
		reqAddr = 24'h00_0000;
		miscompares = 0;
		num_checks = 0;
		modelEn = 5'h05;
		void'($urandom(32'h8c3b));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk) #1;
		chk(24'(p4b4 & p4b7), 24'h00_0001);
		rd(16'hf024, 16'h0005);
		for (int i = 0; i < 32; i++)
		begin
			d = 16'($urandom);
			d[4:0] = 5'(i);
			wr(16'hf024, d);
			modelEn = d[4:0];
			rd(16'hf024, {11'h000, d[4:0]});
			chk(24'({p4b5, p4b6}), {22'h00_0000, {2{~d[0]}}});
			chk(24'({p4b4, p4b7}), {22'h00_0000, {2{~d[1]}}});
			for (int j = 0; j < 9; j++)
				acc(j < 8 ? ADDRS[j] : 24'($urandom_range(32'h0000_ffff)));
		end
		wr(16'hf026, 16'h001f);
		rd(16'hf026, 16'h0000);
		globalXperEnable <= 1'b1;
		wr(16'hf024, {11'h000, ~modelEn});
		#1;
		chk(24'(wrIgnored), 24'h00_0001);
		globalXperEnable <= 1'b0;
		wr(16'hf024, 16'h0000);
		rd(16'hf024, {11'h000, modelEn});
		chk(24'(xperLocked), 24'h00_0001);
		acc(24'h00_ef10);
		complete_run();
	end
endmodule : tb
